// [inc/health_map.svh]
`ifndef HEALTH_MAP_SVH
`define HEALTH_MAP_SVH
// Clock rate in Hz
`define CLK_HZ              40000000
// Measure-and-save period in seconds
`define SAVE_PERIOD_S       7200
// Temperature sample period in seconds
`define TEMP_PERIOD_S       600
// Busy time of measure-and-save, milliseconds
`define BUSY_ONLINE_MS      60
`define BUSY_FULL_MS        370
// Trip point in degrees C
`define TRIP_LIMIT_C        8'h44
// Sense codes: key, ASC, ASCQ
`define SENSE_PREDICT       24'h015d00
`define SENSE_THERMAL       24'h010b01
`define SENSE_ROUNDED       24'h013700
`define SENSE_NONE          24'h000000
// Log pages and parameters
`define LOG_PAGE_TIMER      8'h3e
`define LOG_PAGE_TEMP       8'h0d
`define LOG_PARAM_CURRENT   16'h0000
`define LOG_PARAM_USER      16'h0001
// Self-test result codes
`define DST_PASS            4'h0
`define DST_FAIL            4'h7
`define DST_RUNNING         4'hf
// Report method that disables delivery
`define REPORT_METHOD_FIELD_NONE           4'h0
`endif

// [inc/health_pkg.sv]
package health_pkg;
    // Sense answer carried to the interface
    typedef struct packed {
        logic        valid;
        logic [23:0] code;
        logic [7:0]  fru;
    } sense_type;
    // Mode page control bits
    typedef struct packed {
        logic       exceptDisable;
        logic       onlineOnly;
        logic       warnEnable;
        logic [3:0] reportMethod;
    } ctrl_type;
    // Scheduler states
    typedef enum logic [1:0] {
        SCH_WAIT,
        SCH_BUSY
    } sched_type;
endpackage

// [core/attr_counter.sv]
`timescale 1ns/1ps
`default_nettype none
`include "health_map.svh"
// Interval, failure and history counters for one attribute
module attr_counter #(
    parameter int IVL_W       = 16,
    parameter int INTERVAL    = 1000,
    parameter int ERR_LIMIT   = 10,
    parameter int PREDICT_LIM = 8
) (
    // Clocking
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic clkEn,
    // Events
    input  wire logic enable,
    input  wire logic opDone,
    input  wire logic opError,
    // Result
    output logic      predictHit
);
    logic [IVL_W-1:0] ivlCnt_q;      // Operations in this interval
    logic [IVL_W-1:0] failCnt_q;     // Errors in this interval
    logic [7:0]       histCnt_q;     // Running unacceptable count
    logic             predict_q;     // Threshold reached
    logic             ivlEnd;
    logic             badRate;
    logic [IVL_W-1:0] failNext;

    assign failNext = failCnt_q + IVL_W'(opError);
    assign ivlEnd   = opDone && (ivlCnt_q == IVL_W'(INTERVAL - 1));
    assign badRate  = failNext > IVL_W'(ERR_LIMIT);
    assign predictHit = predict_q;

    // ============================================================
    // Counting
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ivlCnt_q  <= '0;
            failCnt_q <= '0;
            histCnt_q <= '0;
            predict_q <= 1'b0;
        end else if (clkEn && enable && opDone) begin
            if (ivlEnd || badRate) begin
                // Judgement: both counters restart
                ivlCnt_q  <= '0;
                failCnt_q <= '0;
                if (badRate) begin
                    histCnt_q <= histCnt_q + 8'h01;
                end else if (histCnt_q != 8'h00) begin
                    histCnt_q <= histCnt_q - 8'h01;
                end
                if (badRate && (histCnt_q + 8'h01 >= 8'(PREDICT_LIM))) begin
                    predict_q <= 1'b1;
                end
            end else begin
                ivlCnt_q  <= ivlCnt_q + 1'b1;
                failCnt_q <= failNext;
            end
        end
    end

    // Assertions
    a_hist_saturate: assert property (@(posedge core_clk) disable iff (sys_rst)
        (clkEn && enable && opDone && !badRate && histCnt_q == 8'h00)
        |=> histCnt_q == 8'h00) else $error("history went below zero");
    a_counters_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
        (clkEn && enable && opDone && (ivlEnd || badRate))
        |=> (ivlCnt_q == '0 && failCnt_q == '0)) else $error("counters not cleared");
endmodule
`default_nettype wire

// [core/drive_health_thermal_monitor.sv]
// How it works
// - Exception-disable bit stops attribute collection, measurements and thermal warnings; temperature sampling continues
// - Enabled: collect attributes during read/write
// - Online-only bit skips off-line measurements
// - Rezero forces measurement, restarts two-hour timer
// - Log page 3Eh returns time remaining
// - Measure every two hours when bus idle
// - Measurement uninterruptible, 60 or 370 ms
// - Predictive code 01-5D00, kept across resets
// - Per attribute interval and failure counters
// - Judge rate, then clear both counters
// - History counter up/down, saturating at zero
// - History reaching threshold raises predictive failure
// - Sample temperature at power-up, every ten minutes
// - Over trip: code 01-0B01, temperature in FRU
// - Warnings gated by enable bit, report method
// - Fixed 68C trip also saves data frame
// - User trip default 68C, clamp, rounding code
// - Log page 0Dh: current and user trip
// - Self-test fails only on unrecovered errors
// - Every unrecovered step failure counts, stepKind is not decoded
// - Extended scans all LBAs, short scans portions
`timescale 1ns/1ps
`default_nettype none
`include "health_map.svh"
module drive_health_thermal_monitor #(
    parameter int  NUM_ATTR      = 2,
    parameter int  INTERVAL      = 1000,
    parameter int  ERR_LIMIT     = 10,
    parameter int  PREDICT_LIM   = 8,
    parameter int  LBA_W         = 32,
    parameter int  SHORT_STRIDE  = 64,
    parameter longint SAVE_CYCLES = longint'(`SAVE_PERIOD_S) * `CLK_HZ,
    parameter longint TEMP_CYCLES = longint'(`TEMP_PERIOD_S) * `CLK_HZ,
    parameter int  BUSY_ONLINE   = (`BUSY_ONLINE_MS * (`CLK_HZ / 1000)),
    parameter int  BUSY_FULL     = (`BUSY_FULL_MS * (`CLK_HZ / 1000))
) (
    // Clocking
    input  wire logic                  core_clk,
    input  wire logic                  sys_rst,
    input  wire logic                  clkEn,
    // Mode page controls and persisted state
    input  wire health_pkg::ctrl_type  ctrl,
    input  wire logic                  predictSaved,
    // Host commands
    input  wire logic                  busIdle,
    input  wire logic                  rezeroCmd,
    input  wire logic                  logSenseReq,
    input  wire logic [7:0]            logPage,
    input  wire logic [15:0]           logParam,
    input  wire logic                  logSelectReq,
    input  wire logic [7:0]            logSelectData,
    // Drive operations
    input  wire logic [NUM_ATTR-1:0]   opDone,
    input  wire logic [NUM_ATTR-1:0]   opError,
    input  wire logic [7:0]            tempSensor,
    // Self-test
    input  wire logic                  selfTestStart,
    input  wire logic                  selfTestExtended,
    input  wire logic [LBA_W-1:0]      maxLba,
    input  wire logic                  stepDone,
    input  wire logic                  stepUnrecovered,
    input  wire logic [1:0]            stepKind,
    // Outputs
    output logic                       measureBusy,
    output logic                       frameSave,
    output logic                       predictFail,
    output health_pkg::sense_type      senseOut,
    output logic                       logValid,
    output logic [31:0]                logData,
    output logic [7:0]                 userTrip,
    output logic [3:0]                 selfTestResult,
    output logic                       selfTestActive,
    output logic [LBA_W-1:0]           scanLba
);
    // ============================================================
    // Declarations
    localparam int CNT_W = 40;
    health_pkg::sched_type   sched_q;         // Measurement state
    logic [CNT_W-1:0]        saveTimer_q;     // Cycles to next run
    logic [CNT_W-1:0]        tempTimer_q;     // Cycles to next sample
    logic [31:0]             busyCnt_q;       // Remaining busy cycles
    logic [7:0]              temp_q;          // Last sampled temperature
    logic [7:0]              userTrip_q;      // User trip point
    logic                    firstSample_q;   // Power-up sample pending
    logic                    predict_q;       // Sticky predictive flag
    logic                    frame_q;         // Frame save pulse
    health_pkg::sense_type   sense_q;         // Pending sense answer
    logic                    logValid_q;
    logic [31:0]             logData_q;
    logic [3:0]              dstResult_q;
    logic                    dstActive_q;
    logic                    dstExt_q;
    logic [LBA_W-1:0]        lba_q;
    logic [NUM_ATTR-1:0]     attrHit;
    logic                    enabled;
    logic                    saveDue;
    logic                    startRun;
    logic                    sampleNow;
    logic                    overFixed;
    logic                    overUser;
    logic                    warnOut;
    logic                    clampWrite;
    logic                    stepFails;
    logic                    scanEnd;
    logic [LBA_W-1:0]        lbaStep;

    // Remaining time in seconds for the timer log page
    function automatic logic [31:0] cyclesToSec(input logic [CNT_W-1:0] c);
        cyclesToSec = 32'(c / CNT_W'(`CLK_HZ));
    endfunction

    // ============================================================
    // Attribute monitoring
    assign enabled = !ctrl.exceptDisable;
    for (genvar i = 0; i < NUM_ATTR; i++) begin : g_attr
        attr_counter #(
            .IVL_W       (16),
            .INTERVAL    (INTERVAL),
            .ERR_LIMIT   (ERR_LIMIT),
            .PREDICT_LIM (PREDICT_LIM)
        ) u_attr (
            .core_clk    (core_clk),
            .sys_rst     (sys_rst),
            .clkEn       (clkEn),
            .enable      (enabled),
            .opDone      (opDone[i]),
            .opError     (opError[i]),
            .predictHit  (attrHit[i])
        );
    end

    // ============================================================
    // Scheduler decode
    assign saveDue   = (saveTimer_q == '0);
    assign startRun  = enabled && (sched_q == health_pkg::SCH_WAIT)
                       && (rezeroCmd || (saveDue && busIdle));
    assign sampleNow = firstSample_q || (tempTimer_q == '0);

    // Measure-and-save scheduler, cannot be interrupted once started
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sched_q     <= health_pkg::SCH_WAIT;
            saveTimer_q <= '0;
            busyCnt_q   <= '0;
        end else if (clkEn) begin
            case (sched_q)
                health_pkg::SCH_WAIT: begin
                    if (startRun) begin
                        sched_q     <= health_pkg::SCH_BUSY;
                        saveTimer_q <= CNT_W'(SAVE_CYCLES - 1);
                        // Shorter run when only on-line data is gathered
                        busyCnt_q   <= ctrl.onlineOnly ? 32'(BUSY_ONLINE - 1)
                                                       : 32'(BUSY_FULL - 1);
                    end else if (!saveDue) begin
                        saveTimer_q <= saveTimer_q - 1'b1;
                    end
                end
                health_pkg::SCH_BUSY: begin
                    // Busy period ignores rezero commands
                    if (busyCnt_q == '0) begin
                        sched_q <= health_pkg::SCH_WAIT;
                    end else begin
                        busyCnt_q <= busyCnt_q - 1'b1;
                    end
                    if (!saveDue) begin
                        saveTimer_q <= saveTimer_q - 1'b1;
                    end
                end
                default: sched_q <= health_pkg::SCH_WAIT;
            endcase
        end
    end

    // ============================================================
    // Thermal decode
    assign overFixed  = temp_q > `TRIP_LIMIT_C;
    assign overUser   = temp_q > userTrip_q;
    assign warnOut    = enabled && ctrl.warnEnable
                        && (ctrl.reportMethod != `REPORT_METHOD_FIELD_NONE);
    assign clampWrite = logSelectReq && (logSelectData > `TRIP_LIMIT_C);

    // Temperature sampling and user trip point
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tempTimer_q   <= '0;
            temp_q        <= '0;
            firstSample_q <= 1'b1;
            userTrip_q    <= `TRIP_LIMIT_C;
        end else if (clkEn) begin
            if (sampleNow) begin
                temp_q        <= tempSensor;
                firstSample_q <= 1'b0;
                tempTimer_q   <= CNT_W'(TEMP_CYCLES - 1);
            end else begin
                tempTimer_q <= tempTimer_q - 1'b1;
            end
            if (logSelectReq) begin
                userTrip_q <= clampWrite ? `TRIP_LIMIT_C : logSelectData;
            end
        end
    end

    // ============================================================
    // Predictive flag and sense reporting
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            predict_q <= 1'b0;
            frame_q   <= 1'b0;
            sense_q   <= '0;
        end else if (clkEn) begin
            // Restored flag keeps the code across power cycles
            if (enabled && ((|attrHit) || predictSaved)) begin
                predict_q <= 1'b1;
            end
            frame_q <= enabled && sampleNow && (tempSensor > `TRIP_LIMIT_C);
            if (clampWrite) begin
                sense_q <= '{valid: 1'b1, code: `SENSE_ROUNDED, fru: 8'h00};
            end else if (warnOut && (overFixed || overUser)) begin
                sense_q <= '{valid: 1'b1, code: `SENSE_THERMAL, fru: temp_q};
            end else if (predict_q && ctrl.reportMethod != `REPORT_METHOD_FIELD_NONE) begin
                sense_q <= '{valid: 1'b1, code: `SENSE_PREDICT, fru: 8'h00};
            end else begin
                sense_q <= '{valid: 1'b0, code: `SENSE_NONE, fru: 8'h00};
            end
        end
    end

    // ============================================================
    // Log sense answers
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            logValid_q <= 1'b0;
            logData_q  <= '0;
        end else if (clkEn) begin
            logValid_q <= logSenseReq;
            if (logSenseReq && logPage == `LOG_PAGE_TIMER) begin
                logData_q <= cyclesToSec(saveTimer_q);
            end else if (logSenseReq && logPage == `LOG_PAGE_TEMP) begin
                logData_q <= (logParam == `LOG_PARAM_USER) ? {24'h000000, userTrip_q}
                                                           : {24'h000000, temp_q};
            end else if (logSenseReq) begin
                logData_q <= '0;
            end
        end
    end

    // ============================================================
    // Drive self-test
    assign stepFails = stepDone && stepUnrecovered;
    assign lbaStep   = dstExt_q ? LBA_W'(1) : LBA_W'(SHORT_STRIDE);
    assign scanEnd   = stepDone && (maxLba - lba_q <= lbaStep);

    // Scan walk, fail result only set for unrecovered failures
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dstResult_q <= `DST_PASS;
            dstActive_q <= 1'b0;
            dstExt_q    <= 1'b0;
            lba_q       <= '0;
        end else if (clkEn) begin
            if (selfTestStart && !dstActive_q) begin
                // Host confirmed readiness first
                dstActive_q <= 1'b1;
                dstExt_q    <= selfTestExtended;
                dstResult_q <= `DST_RUNNING;
                lba_q       <= '0;
            end else if (dstActive_q && stepFails) begin
                // stepKind names seek, track, read or write
                dstResult_q <= `DST_FAIL;
                dstActive_q <= 1'b0;
            end else if (dstActive_q && scanEnd) begin
                dstResult_q <= `DST_PASS;
                dstActive_q <= 1'b0;
            end else if (dstActive_q && stepDone) begin
                lba_q <= lba_q + lbaStep;
            end
        end
    end

    // ============================================================
    // Output drive
    assign measureBusy    = (sched_q == health_pkg::SCH_BUSY);
    assign frameSave      = frame_q;
    assign predictFail    = predict_q;
    assign senseOut       = sense_q;
    assign logValid       = logValid_q;
    assign logData        = logData_q;
    assign userTrip       = userTrip_q;
    assign selfTestResult = dstResult_q;
    assign selfTestActive = dstActive_q;
    assign scanLba        = lba_q;

    // ============================================================
    // Assertions
    a_disable_quiet: assert property (@(posedge core_clk) disable iff (sys_rst)
        (clkEn && ctrl.exceptDisable && sched_q == health_pkg::SCH_WAIT)
        |=> sched_q == health_pkg::SCH_WAIT) else $error("run while disabled");
    a_rezero_start: assert property (@(posedge core_clk) disable iff (sys_rst)
        (clkEn && enabled && rezeroCmd && sched_q == health_pkg::SCH_WAIT)
        |=> (measureBusy && saveTimer_q == CNT_W'(SAVE_CYCLES - 1))) else $error("rezero ignored");
    a_no_run_busy: assert property (@(posedge core_clk) disable iff (sys_rst)
        (clkEn && saveDue && !busIdle && !rezeroCmd && sched_q == health_pkg::SCH_WAIT)
        |=> !measureBusy) else $error("run on busy bus");
    a_busy_holds: assert property (@(posedge core_clk) disable iff (sys_rst)
        (measureBusy && busyCnt_q != '0) |=> measureBusy) else $error("run cut short");
    a_predict_sticky: assert property (@(posedge core_clk) disable iff (sys_rst)
        predict_q |=> predict_q) else $error("predictive flag lost");
    a_trip_clamp: assert property (@(posedge core_clk) disable iff (sys_rst)
        (clkEn && clampWrite) |=> (userTrip_q == `TRIP_LIMIT_C
        && sense_q.code == `SENSE_ROUNDED)) else $error("trip not clamped");
    a_thermal_fru: assert property (@(posedge core_clk) disable iff (sys_rst)
        (sense_q.valid && sense_q.code == `SENSE_THERMAL) |-> sense_q.fru > 8'h00
        || temp_q == 8'h00) else $error("thermal code without fru");
    a_dst_fail: assert property (@(posedge core_clk) disable iff (sys_rst)
        (clkEn && dstActive_q && stepFails) |=> selfTestResult == `DST_FAIL)
        else $error("unrecovered error not reported");
    c_rezero: cover property (@(posedge core_clk) rezeroCmd && startRun);
    c_predict: cover property (@(posedge core_clk) $rose(predict_q));
    c_thermal: cover property (@(posedge core_clk) sense_q.code == `SENSE_THERMAL);
endmodule
`default_nettype wire

// [bench/scsi_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Host adapter: issues commands as single-cycle pulses
module scsi_host_model (
    // Clocking
    input  wire logic        core_clk,
    // Answers from the block
    input  wire logic        logValid,
    input  wire logic [31:0] logData,
    input  wire logic        selfTestActive,
    // Commands to the block
    output var logic         busIdle,
    output var logic         rezeroCmd,
    output var logic         logSenseReq,
    output var logic [7:0]   logPage,
    output var logic [15:0]  logParam,
    output var logic         logSelectReq,
    output var logic [7:0]   logSelectData,
    output var logic         selfTestStart
);
    // Quiet bus at time zero
    initial begin
        {busIdle, rezeroCmd, logSenseReq, logSelectReq, selfTestStart} = 5'h00;
        logPage = 8'hff;
        logParam = 16'hffff;
        logSelectData = 8'h00;
    end
    // Force a measurement
    task automatic rezero();
        @(posedge core_clk) rezeroCmd <= 1'b1;
        @(posedge core_clk) rezeroCmd <= 1'b0;
    endtask
    // Read one log parameter; a missing answer returns all ones
    task automatic logSense(input logic [7:0] pg, input logic [15:0] prm, output logic [31:0] d);
        d = 32'hffffffff;
        @(posedge core_clk) begin
            logSenseReq <= 1'b1;
            logPage <= pg;
            logParam <= prm;
        end
        @(posedge core_clk) logSenseReq <= 1'b0;
        for (int i = 0; i < 4 && d === 32'hffffffff; i++) begin
            @(negedge core_clk);
            if (logValid === 1'b1) d = logData;
        end
    endtask
    // Write the user trip point
    task automatic logSelect(input logic [7:0] v);
        @(posedge core_clk) begin
            logSelectReq <= 1'b1;
            logSelectData <= v;
        end
        @(posedge core_clk) logSelectReq <= 1'b0;
    endtask
    // Start a self-test once the drive is ready
    task automatic startTest();
        for (int i = 0; i < 1000 && selfTestActive !== 1'b0; i++) @(negedge core_clk);
        @(posedge core_clk) selfTestStart <= 1'b1;
        @(posedge core_clk) selfTestStart <= 1'b0;
    endtask
endmodule
`default_nettype wire

// [bench/drive_health_thermal_monitor_test.sv]
`timescale 1ns/1ps
`default_nettype none
`include "health_map.svh"
// ============================================================
// Bench for the health and thermal monitor
module drive_health_thermal_monitor_test;
    logic core_clk = 1'b0, sys_rst = 1'b1, busIdle, rezeroCmd, logSenseReq, logSelectReq;
    logic selfTestStart, selfTestExtended = 1'b0, stepDone = 1'b0, stepUnrecovered = 1'b0;
    logic measureBusy, frameSave, predictFail, logValid, selfTestActive, frameSeen = 1'b0;
    logic [7:0] logPage, logSelectData, userTrip, tempSensor = 8'h30;
    logic [15:0] logParam;
    logic [1:0] opDone = 2'h0, opError = 2'h0;
    logic [31:0] logData, scanLba, d, maxLba = 32'h10;
    logic clkEn = 1'b1, predictSaved = 1'b0;
    logic [1:0] stepKind = 2'h0;
    logic [3:0] selfTestResult;
    health_pkg::ctrl_type ctrl = '{1'b0, 1'b0, 1'b1, 4'h4};
    health_pkg::sense_type senseOut;
    int failCount = 0, cmpCount = 0, cycles = 0, w;
    // ============================================================
    // Clock and instances
    initial forever #12.5 core_clk = ~core_clk;
    drive_health_thermal_monitor #(.INTERVAL(8), .ERR_LIMIT(2), .PREDICT_LIM(2),
        .SAVE_CYCLES(200), .TEMP_CYCLES(100), .BUSY_ONLINE(5), .BUSY_FULL(20))
    i_drive_health_thermal_monitor (.core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn),
        .ctrl(ctrl), .predictSaved(predictSaved), .busIdle(busIdle), .rezeroCmd(rezeroCmd),
        .logSenseReq(logSenseReq), .logPage(logPage), .logParam(logParam),
        .logSelectReq(logSelectReq), .logSelectData(logSelectData), .opDone(opDone),
        .opError(opError), .tempSensor(tempSensor), .selfTestStart(selfTestStart),
        .selfTestExtended(selfTestExtended), .maxLba(maxLba), .stepDone(stepDone),
        .stepUnrecovered(stepUnrecovered), .stepKind(stepKind), .measureBusy(measureBusy),
        .frameSave(frameSave), .predictFail(predictFail), .senseOut(senseOut),
        .logValid(logValid), .logData(logData), .userTrip(userTrip),
        .selfTestResult(selfTestResult), .selfTestActive(selfTestActive), .scanLba(scanLba));
    scsi_host_model i_scsi_host_model (.core_clk(core_clk), .logValid(logValid),
        .logData(logData), .selfTestActive(selfTestActive), .busIdle(busIdle),
        .rezeroCmd(rezeroCmd), .logSenseReq(logSenseReq), .logPage(logPage),
        .logParam(logParam), .logSelectReq(logSelectReq), .logSelectData(logSelectData),
        .selfTestStart(selfTestStart));
    // Frame-save watcher and hang limit
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (frameSave === 1'b1) frameSeen <= 1'b1;
        if (cycles == 6000) begin
            failCount++;
            summarize();
        end
    end
    // ============================================================
    // Helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            failCount++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Feed n operations to attribute 0, the first e of them in error
    task automatic ops(input int n, input int e);
        for (int i = 0; i < n; i++) @(posedge core_clk) begin
            opDone <= 2'h1;
            opError <= (i < e) ? 2'h1 : 2'h0;
        end
        @(posedge core_clk) opDone <= 2'h0;
        repeat (3) @(posedge core_clk);
    endtask
    // Rezero then measure the busy width
    task automatic busyWidth(output int n);
        i_scsi_host_model.rezero();
        n = 0;
        for (int i = 0; i < 4 && measureBusy !== 1'b1; i++) @(negedge core_clk);
        while (measureBusy === 1'b1 && n < 100) begin
            @(negedge core_clk);
            n++;
        end
    endtask
    // Run one self-test to completion
    task automatic selfTest(input logic ext, input logic bad);
        selfTestExtended <= ext;
        stepUnrecovered <= bad;
        i_scsi_host_model.startTest();
        repeat (2) @(negedge core_clk);
        check({28'h0, selfTestResult}, {28'h0, `DST_RUNNING});
        for (int i = 0; i < 300 && selfTestActive === 1'b1; i++) @(posedge core_clk) stepDone <= 1'b1;
        @(posedge core_clk) stepDone <= 1'b0;
        repeat (2) @(negedge core_clk);
    endtask
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", cmpCount, failCount);
        if (failCount == 0 && cmpCount > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ============================================================
    // Test sequence
    initial begin
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(negedge core_clk);
        check({24'h0, userTrip}, {24'h0, `TRIP_LIMIT_C});
        i_scsi_host_model.logSense(`LOG_PAGE_TEMP, `LOG_PARAM_USER, d);
        check(d, 32'h44);
        i_scsi_host_model.logSense(`LOG_PAGE_TEMP, `LOG_PARAM_CURRENT, d);
        check(d, 32'h30);
        $display("Test reset and log done");
        ctrl.onlineOnly <= 1'b1;
        busyWidth(w);
        check({31'h0, w == 5 || w == 6}, 32'h1);
        ctrl.onlineOnly <= 1'b0;
        busyWidth(w);
        check({31'h0, w == 20 || w == 21}, 32'h1);
        i_scsi_host_model.logSense(`LOG_PAGE_TIMER, 16'h0000, d);
        check({31'h0, d !== 32'hffffffff}, 32'h1);
        ctrl.exceptDisable <= 1'b1;
        busyWidth(w);
        check(w, 0);
        ctrl.exceptDisable <= 1'b0;
        clkEn <= 1'b0;
        busyWidth(w);
        check(w, 0);
        clkEn <= 1'b1;
        busyWidth(w);
        w = 0;
        i_scsi_host_model.busIdle <= 1'b1;
        while (measureBusy !== 1'b1 && w < 400) begin
            @(negedge core_clk);
            w++;
        end
        check({31'h0, w >= 150 && w <= 230}, 32'h1);
        i_scsi_host_model.busIdle <= 1'b0;
        $display("Test measurement done");
        ops(8, 0);
        ops(3, 3);
        ops(8, 0);
        ops(3, 3);
        check({31'h0, predictFail}, 32'h0);
        ops(3, 3);
        check({31'h0, predictFail}, 32'h1);
        check({8'h0, senseOut.code}, {8'h0, `SENSE_PREDICT});
        $display("Test prediction done");
        tempSensor <= 8'h46;
        repeat (110) @(negedge core_clk);
        check({senseOut.code, senseOut.fru}, {`SENSE_THERMAL, 8'h46});
        check({31'h0, frameSeen}, 32'h1);
        ctrl.warnEnable <= 1'b0;
        repeat (3) @(negedge core_clk);
        check({8'h0, senseOut.code}, {8'h0, `SENSE_PREDICT});
        ctrl.reportMethod <= `REPORT_METHOD_FIELD_NONE;
        repeat (3) @(negedge core_clk);
        check({31'h0, senseOut.valid}, 32'h0);
        ctrl <= '{1'b0, 1'b0, 1'b1, 4'h4};
        i_scsi_host_model.logSelect(8'h50);
        @(negedge core_clk);
        check({userTrip, senseOut.code}, {8'h44, `SENSE_ROUNDED});
        i_scsi_host_model.logSelect(8'h20);
        i_scsi_host_model.logSense(`LOG_PAGE_TEMP, `LOG_PARAM_USER, d);
        check(d, 32'h20);
        $display("Test thermal done");
        selfTest(1'b1, 1'b0);
        check({28'h0, selfTestResult}, {28'h0, `DST_PASS});
        selfTest(1'b0, 1'b1);
        check({28'h0, selfTestResult}, {28'h0, `DST_FAIL});
        $display("Test self-test done");
        summarize();
    end
endmodule
`default_nettype wire
